// >>> ntbdcs_pkg.sv
// Behaviour
// - Control bit 0 is a read-write correctable error reporting enable, reset zero.
// - Control bit 1 is a read-write non-fatal error reporting enable, reset zero.
// - Control bit 2 is a read-write fatal error reporting enable, reset zero.
// - Control bit 3 is a read-write unsupported request reporting enable, reset zero.
// - Relaxed ordering bit 4 clear forces strong ordering on crossing traffic; resets one.
// - Relaxed ordering bit set passes the crossing ordering attribute unchanged.
// - Bits 7:5 hold max payload, reset zero; codes 0-4 give 128 to 2048 bytes.
// - Reserved max payload codes 5 to 7 act as a 128 byte limit.
// - Tags pass unchanged, originated tags are zero; extended tag bit 8 is inert.
// - Phantom function bit 9 reads zero and ignores writes.
// - Auxiliary power bit 10 is read-only zero.
// - No Snoop never originated, passed unchanged; bit 11 stored without effect.
// - Max read request bits 14:12 reset to 2, inert; originated reads capped at 128.
// - Status bit 0 sets on correctable error, write-one clears, reset zero.
// - Status bit 1 sets on non-fatal error, write-one clears, reset zero.
// - Status bit 2 sets on fatal error, write-one clears, reset zero.
// - Status flags record errors regardless of the reporting enables.
// - Status bit 3 sets on unsupported request, write-one clears, regardless of enable.
package ntbdcs_pkg;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [7:0] DEV_CTRL_IDX = 8'h48;
  localparam logic [7:0] DEV_STAT_IDX = 8'h4A;
  localparam int unsigned MIN_ADDR_W = 10;

  // Control register layout.
  localparam int unsigned COR_EN_BIT = 0;
  localparam int unsigned NONFATAL_EN_BIT = 1;
  localparam int unsigned FATAL_EN_BIT = 2;
  localparam int unsigned UNSUP_EN_BIT = 3;
  localparam int unsigned RELAXED_EN_BIT = 4;
  localparam int unsigned MPS_LSB = 5;
  localparam int unsigned MPS_MSB = 7;
  localparam int unsigned EXT_TAG_BIT = 8;
  localparam int unsigned NO_SNOOP_BIT = 11;
  localparam int unsigned MAX_READ_REQUEST_SIZE_LSB = 12;
  localparam int unsigned MAX_READ_REQUEST_SIZE_MSB = 14;
  localparam logic [15:0] CTRL_RESET = 16'h2010;
  localparam logic [15:0] CTRL_WMASK = 16'h79FF;

  // Status register layout; flag order is correctable, non-fatal, fatal, unsupported.
  localparam int unsigned STAT_W = 4;
  localparam logic [3:0] STAT_RESET = 4'h0;

  // Payload sizes.
  localparam logic [2:0] MPS_MAX_ENC = 3'h4;
  localparam int unsigned PAYLOAD_W = 12;
  localparam logic [11:0] BASE_PAYLOAD_BYTES = 12'h080;
  localparam logic [9:0] ORIG_MAX_LEN_DW = 10'h020;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEV_COR = 2'b00,
    SEV_NONFATAL = 2'b01,
    SEV_FATAL = 2'b10
  } ntbdcs_sev_t;

  typedef enum logic {
    MSG_IDLE = 1'b0,
    MSG_SEND = 1'b1
  } ntbdcs_msg_state_t;

  typedef struct packed {
    logic relaxed_ord;
    logic no_snoop;
    logic [7:0] tag;
    logic [9:0] len_dw;
  } ntbdcs_tlp_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } ntbdcs_wdata_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } ntbdcs_rdata_t;

  typedef struct packed {
    logic unsup;
    logic fatal;
    logic nonfatal;
    logic cor;
  } ntbdcs_err_t;

endpackage

// >>> ntbdcs_tlp_fix.sv
`timescale 1ns/1ns
`default_nettype none
module ntbdcs_tlp_fix (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic relaxed_ordering_en,
  input wire logic pass_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t pass_tlp,
  input wire logic orig_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t orig_tlp,
  output logic pass_valid_q,
  output ntbdcs_pkg::ntbdcs_tlp_t pass_tlp_q,
  output logic orig_valid_q,
  output ntbdcs_pkg::ntbdcs_tlp_t orig_tlp_q
);
  import ntbdcs_pkg::*;

  ntbdcs_tlp_t pass_d;
  ntbdcs_tlp_t orig_d;

  // Crossing traffic keeps tag, snoop and size; only the ordering bit may change.
  always_comb begin
    pass_d = pass_tlp;
    pass_d.relaxed_ord = pass_tlp.relaxed_ord & relaxed_ordering_en;
  end

  // Local requests carry a zero tag, never No Snoop, and at most 128 bytes.
  always_comb begin
    orig_d = orig_tlp;
    orig_d.tag = 8'h00;
    orig_d.no_snoop = 1'b0;
    if (orig_tlp.len_dw > ORIG_MAX_LEN_DW) begin
      orig_d.len_dw = ORIG_MAX_LEN_DW;
    end
  end

  // One register stage for each stream; nothing is held back, so no ready is needed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pass_valid_q <= 1'b0;
      pass_tlp_q <= '0;
      orig_valid_q <= 1'b0;
      orig_tlp_q <= '0;
    end else begin
      pass_valid_q <= pass_valid;
      pass_tlp_q <= pass_d;
      orig_valid_q <= orig_valid;
      orig_tlp_q <= orig_d;
    end
  end

endmodule
`default_nettype wire

// >>> ntbdcs_top.sv
`timescale 1ns/1ns
`default_nettype none
module ntbdcs_top #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data.
  input wire logic wvalid,
  output logic wready,
  input wire ntbdcs_pkg::ntbdcs_wdata_t wpayload,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address.
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data.
  output logic rvalid,
  input wire logic rready,
  output ntbdcs_pkg::ntbdcs_rdata_t rpayload,
  // Error events from the function's own logic, one-cycle pulses.
  input wire ntbdcs_pkg::ntbdcs_err_t err_evt,
  // Upstream error message request.
  output logic err_msg_valid,
  input wire logic err_msg_ready,
  output ntbdcs_pkg::ntbdcs_sev_t err_msg_sev,
  // Traffic from the opposite side.
  input wire logic pass_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t pass_tlp,
  output logic pass_out_valid,
  output ntbdcs_pkg::ntbdcs_tlp_t pass_out_tlp,
  // Requests originated by this function's endpoints.
  input wire logic orig_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t orig_tlp,
  output logic orig_out_valid,
  output ntbdcs_pkg::ntbdcs_tlp_t orig_out_tlp,
  // Payload limit in bytes for the datapath.
  output logic [11:0] max_payload_bytes
);
  import ntbdcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check.

  // The check demands ten address bits; the status register's word index needs only seven.
  if (ADDR_W < MIN_ADDR_W) begin : g_addr_check
    $error("ADDR_W is too narrow to reach the device registers.");
  end

  localparam logic [ADDR_W-3:0] CTRL_WORD = (ADDR_W-2)'(DEV_CTRL_IDX);
  localparam logic [ADDR_W-3:0] STAT_WORD = (ADDR_W-2)'(DEV_STAT_IDX);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  ntbdcs_rdata_t rpayload_q;
  logic aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  ntbdcs_wdata_t w_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic commit;
  logic wr_ctrl;
  logic wr_stat;
  logic [15:0] lane_mask;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [2:0] pend_q;
  logic [2:0] pend_set;
  logic [2:0] pend_take;
  ntbdcs_msg_state_t msg_state_q;
  ntbdcs_sev_t msg_sev_q;
  logic msg_valid_q;
  ntbdcs_sev_t pick_sev;
  logic [11:0] payload_q;
  logic [15:0] rd_word;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes.

  // A channel moves an item when valid and ready are high on the same edge.
  assign aw_hs = awvalid & awready_q;
  assign w_hs = wvalid & wready_q;
  assign ar_hs = arvalid & arready_q;
  assign commit = aw_held_q & w_held_q & ~bvalid_q;

  // Protection attributes are accepted and not checked.
  assign wr_ctrl = commit & (aw_addr_q[ADDR_W-1:2] == CTRL_WORD);
  assign wr_stat = commit & (aw_addr_q[ADDR_W-1:2] == STAT_WORD);

  // Byte strobes select which halves of the 16-bit register a write reaches.
  assign lane_mask = {{8{w_q.strb[1]}}, {8{w_q.strb[0]}}};

  // The address is caught alone, and accepted again only once the response is gone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (!aw_held_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (commit) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // Write data is caught in the same way, so either channel may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b0;
      w_q <= '0;
    end else begin
      if (w_hs) begin
        wready_q <= 1'b0;
        w_held_q <= 1'b1;
        w_q <= wpayload;
      end else if (!w_held_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (commit) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // The response follows the edge on which both halves are applied.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device control register.

  // Only writable bits take the new value; bits 9, 10 and 15 keep their zero.
  assign ctrl_d = (ctrl_q & ~(CTRL_WMASK & lane_mask)) |
                  (w_q.data[15:0] & CTRL_WMASK & lane_mask);

  // The enables, ordering, payload, tag, snoop and read size fields live here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_d;
    end
  end

  // The payload limit is decoded once into bytes for the datapath.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      payload_q <= BASE_PAYLOAD_BYTES;
    end else if (ctrl_q[MPS_MSB:MPS_LSB] > MPS_MAX_ENC) begin
      payload_q <= BASE_PAYLOAD_BYTES;
    end else begin
      payload_q <= BASE_PAYLOAD_BYTES << ctrl_q[MPS_MSB:MPS_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device status register.

  // Flags log every detected error, whatever the reporting enables hold.
  assign stat_set = {err_evt.unsup, err_evt.fatal, err_evt.nonfatal, err_evt.cor};
  assign stat_clr = wr_stat ? (w_q.data[STAT_W-1:0] & {STAT_W{w_q.strb[0]}}) : '0;

  // An error arriving on the clearing edge survives, since setting wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= STAT_RESET;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error messages.

  // Unsupported requests are reported with non-fatal severity.
  assign pend_set = {err_evt.fatal & ctrl_q[FATAL_EN_BIT],
                     (err_evt.nonfatal & ctrl_q[NONFATAL_EN_BIT]) |
                     (err_evt.unsup & ctrl_q[UNSUP_EN_BIT]),
                     err_evt.cor & ctrl_q[COR_EN_BIT]};

  // The most severe pending message goes first.
  always_comb begin
    pick_sev = SEV_COR;
    pend_take = 3'h0;
    if (pend_q[2]) begin
      pick_sev = SEV_FATAL;
      pend_take = 3'h4;
    end else if (pend_q[1]) begin
      pick_sev = SEV_NONFATAL;
      pend_take = 3'h2;
    end else if (pend_q[0]) begin
      pick_sev = SEV_COR;
      pend_take = 3'h1;
    end
  end

  // Pending bits merge repeats of one severity into a single message.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 3'h0;
    end else if (msg_state_q == MSG_IDLE) begin
      pend_q <= (pend_q & ~pend_take) | pend_set;
    end else begin
      pend_q <= pend_q | pend_set;
    end
  end

  // A message stands until the upstream logic takes it.
  // The request flag is a flop of its own, so the output comes straight from a register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_state_q <= MSG_IDLE;
      msg_sev_q <= SEV_COR;
      msg_valid_q <= 1'b0;
    end else begin
      case (msg_state_q)
        MSG_IDLE: begin
          if (pend_q != 3'h0) begin
            msg_state_q <= MSG_SEND;
            msg_sev_q <= pick_sev;
            msg_valid_q <= 1'b1;
          end
        end
        MSG_SEND: begin
          if (err_msg_ready) begin
            msg_state_q <= MSG_IDLE;
            msg_valid_q <= 1'b0;
          end
        end
        default: begin
          msg_state_q <= MSG_IDLE;
          msg_valid_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads.

  // Unmapped words read zero with an error response.
  // The upper address bits take part in the match, so aliases of the two words are refused.
  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    if (araddr[ADDR_W-1:2] == CTRL_WORD) begin
      rd_word = ctrl_q;
    end else if (araddr[ADDR_W-1:2] == STAT_WORD) begin
      rd_word = {{(16-STAT_W){1'b0}}, stat_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data is captured on the address edge and stands until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rpayload_q <= '0;
    end else begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rpayload_q <= {16'h0000, rd_word, rd_hit ? RESP_OKAY : RESP_SLVERR};
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath attribute handling.

  ntbdcs_tlp_fix u_tlp_fix (
    .aclk(aclk),
    .aresetn(aresetn),
    .relaxed_ordering_en(ctrl_q[RELAXED_EN_BIT]),
    .pass_valid(pass_valid),
    .pass_tlp(pass_tlp),
    .orig_valid(orig_valid),
    .orig_tlp(orig_tlp),
    .pass_valid_q(pass_out_valid),
    .pass_tlp_q(pass_out_tlp),
    .orig_valid_q(orig_out_valid),
    .orig_tlp_q(orig_out_tlp)
  );

  // Outputs come from registers only.
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rpayload = rpayload_q;
  assign err_msg_valid = msg_valid_q;
  assign err_msg_sev = msg_sev_q;
  assign max_payload_bytes = payload_q;

endmodule
`default_nettype wire

// >>> ntbdcs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ntbdcs_monitor
  import ntbdcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic err_msg_valid,
  input wire logic err_msg_ready,
  input wire ntbdcs_pkg::ntbdcs_sev_t err_msg_sev,
  input wire logic pass_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t pass_tlp,
  input wire logic pass_out_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t pass_out_tlp,
  input wire logic orig_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t orig_tlp,
  input wire logic orig_out_valid,
  input wire ntbdcs_pkg::ntbdcs_tlp_t orig_out_tlp,
  input wire logic [11:0] max_payload_bytes
);
  // One clock domain, so clocking and reset are given once for all.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  //////////////////////////////////////////////////////////////
  // Crossing traffic keeps every field but the ordering bit.
  pass_thru_a: assert property (
    pass_valid |=> pass_out_valid && pass_out_tlp[18:0] == $past(pass_tlp[18:0]))
    else $error("crossing fields altered");
  relax_keep_a: assert property (
    pass_out_valid && pass_out_tlp.relaxed_ord |-> $past(pass_tlp.relaxed_ord))
    else $error("ordering bit set without cause");
  // Originated requests carry a zero tag, no snoop hint and a capped length.
  orig_clean_a: assert property (
    orig_valid |=> orig_out_valid && orig_out_tlp.tag == 8'h00 && !orig_out_tlp.no_snoop)
    else $error("originated tag or snoop wrong");
  orig_cap_a: assert property (
    orig_valid |=> orig_out_tlp.len_dw == ($past(orig_tlp.len_dw) > ORIG_MAX_LEN_DW ?
      ORIG_MAX_LEN_DW : $past(orig_tlp.len_dw)))
    else $error("originated length wrong");
  // The payload limit only ever takes one of the five legal sizes.
  mps_legal_a: assert property (
    max_payload_bytes inside {12'h080, 12'h100, 12'h200, 12'h400, 12'h800})
    else $error("payload limit illegal");
  mps_reset_a: assert property (
    $rose(aresetn) |-> max_payload_bytes == 12'h080)
    else $error("payload limit reset wrong");
  // A message request stands still until it is taken, then drops.
  msg_hold_a: assert property (
    err_msg_valid && !err_msg_ready |=> err_msg_valid && $stable(err_msg_sev))
    else $error("message request dropped early");
  msg_drop_a: assert property (
    err_msg_valid && err_msg_ready |=> !err_msg_valid)
    else $error("message request not released");
endmodule
bind ntbdcs_top ntbdcs_monitor mon (.aclk, .aresetn, .err_msg_valid, .err_msg_ready,
  .err_msg_sev, .pass_valid, .pass_tlp, .pass_out_valid, .pass_out_tlp, .orig_valid,
  .orig_tlp, .orig_out_valid, .orig_out_tlp, .max_payload_bytes);
`default_nettype wire

// >>> ntb_device_control_status_test.sv
`timescale 1ns/1ns
`default_nettype none
module ntb_device_control_status_test;
  import ntbdcs_pkg::*;
  localparam logic [11:0] A_CTRL = {2'b00, DEV_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, DEV_STAT_IDX, 2'b00};
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, err_msg_ready = 1'b0, pass_valid = 1'b0;
  logic orig_valid = 1'b0, awready, wready, bvalid, arready, rvalid, err_msg_valid;
  logic pass_out_valid, orig_out_valid, pv, ov;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, max_payload_bytes;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [1:0] bresp;
  ntbdcs_wdata_t wpayload = '0;
  ntbdcs_rdata_t rpayload;
  ntbdcs_err_t err_evt = '0;
  ntbdcs_sev_t err_msg_sev;
  ntbdcs_tlp_t pass_tlp = '0, orig_tlp = '0, pass_out_tlp, orig_out_tlp, pt, ot;
  int miscompares = 0, cmp_count = 0;
  logic [15:0] m_ctrl = 16'h2010;
  logic [3:0] m_stat = 4'h0;
  logic [20:0] qp[$], qo[$];

  ntbdcs_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wpayload, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rpayload, .err_evt, .err_msg_valid, .err_msg_ready, .err_msg_sev, .pass_valid,
    .pass_tlp, .pass_out_valid, .pass_out_tlp, .orig_valid, .orig_tlp, .orig_out_valid,
    .orig_out_tlp, .max_payload_bytes);

  // Free-running 50 MHz clock.
  always #10 aclk = ~aclk;

  //////////////////////////////////////////////////////////////
  // Compare one value against the model and keep the tally.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // Print counts and verdict, then stop the run.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Full write; the model follows only accepted writes, since refused ones must not land.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    logic [15:0] wm;
    n = 0;
    wm = {s[1] ? 8'hFF : 8'h00, s[0] ? 8'hFF : 8'h00} & 16'h79FF;
    @(posedge aclk);
    awaddr <= a;
    awprot <= 3'($urandom);
    wpayload <= '{data: d, strb: s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk("bvalid", 32'(bvalid), 32'h1);
    chk("bresp", 32'(bresp), 32'(er));
    if (a == A_CTRL && er == RESP_OKAY) m_ctrl = (m_ctrl & ~wm) | (d[15:0] & wm);
    if (a == A_STAT && s[0]) m_stat = m_stat & ~d[3:0];
  endtask

  // Full read with expected data and response.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arprot <= 3'($urandom);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    chk("rvalid", 32'(rvalid), 32'h1);
    chk("rdata", rpayload.data, e);
    chk("rresp", 32'(rpayload.resp), 32'(er));
  endtask

  // One-cycle error event; every detected error is logged in the model.
  task automatic pulse(input logic [3:0] m);
    @(posedge aclk);
    err_evt <= m;
    m_stat = m_stat | m;
    @(posedge aclk);
    err_evt <= '0;
  endtask

  // Wait for a message request, check its severity and take it.
  task automatic msg(input logic [1:0] e);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!err_msg_valid && n < 10);
    chk("msgv", 32'(err_msg_valid), 32'h1);
    chk("sev", 32'(err_msg_sev), 32'(e));
    err_msg_ready <= 1'b1;
    @(posedge aclk);
    err_msg_ready <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(32'h7209));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk("mpb", 32'(max_payload_bytes), 32'h80);
    rd(A_CTRL, 32'h2010, RESP_OKAY);
    rd(A_STAT, 32'h0, RESP_OKAY);
    $display("test reset done");
    // Every payload code with random neighbours; hardwired bits must stay zero.
    for (int i = 0; i < 8; i++) begin
      wr(A_CTRL, ($urandom & 32'hFFFF_FF1F) | (32'(i) << 5), 4'h1 | 4'($urandom & 4'hE),
         RESP_OKAY);
      rd(A_CTRL, {16'h0, m_ctrl}, RESP_OKAY);
      chk("mpb", 32'(max_payload_bytes), i > 4 ? 32'h80 : 32'h80 << i);
    end
    wr(12'h048, 32'h0000_FFFF, 4'hF, RESP_SLVERR);
    rd(12'h048, 32'h0, RESP_SLVERR);
    rd(A_CTRL, {16'h0, m_ctrl}, RESP_OKAY);
    $display("test registers done");
    // Errors with reporting off are logged but never sent.
    wr(A_CTRL, 32'h0, 4'h3, RESP_OKAY);
    for (int k = 0; k < 4; k++) pulse(4'(1 << k));
    repeat (4) @(posedge aclk);
    chk("msg", 32'(err_msg_valid), 32'h0);
    rd(A_STAT, 32'(m_stat), RESP_OKAY);
    wr(A_STAT, 32'hF, 4'h2, RESP_OKAY);
    rd(A_STAT, 32'(m_stat), RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(A_STAT, 32'(1 << k), 4'h1, RESP_OKAY);
      rd(A_STAT, 32'(m_stat), RESP_OKAY);
    end
    // Reporting on: each severity in turn, then all at once by priority.
    wr(A_CTRL, 32'h000F, 4'h1, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      pulse(4'(1 << k));
      msg(k == 3 ? 2'h1 : 2'(k));
    end
    pulse(4'h7);
    msg(2'h2);
    msg(2'h1);
    msg(2'h0);
    $display("test errors done");
    // Back-to-back random traffic both ways, ordering bit clear then set.
    for (int r = 0; r < 2; r++) begin
      wr(A_CTRL, 32'(r) << 4, 4'h1, RESP_OKAY);
      for (int i = 0; i < 42; i++) begin
        @(posedge aclk);
        if (qp.size() == 2) begin
          chk("pass", {pass_out_valid, pass_out_valid ? pass_out_tlp : 20'h0},
              qp.pop_front());
          chk("orig", {orig_out_valid, orig_out_valid ? orig_out_tlp : 20'h0},
              qo.pop_front());
        end
        pv = i < 40 ? 1'($urandom) : 1'b0;
        ov = i < 40 ? 1'($urandom) : 1'b0;
        pt = 20'($urandom);
        ot = 20'($urandom);
        pass_valid <= pv;
        pass_tlp <= pt;
        orig_valid <= ov;
        orig_tlp <= ot;
        qp.push_back(pv ? {1'b1, pt.relaxed_ord & r[0], pt[18:0]} : 21'h0);
        qo.push_back(ov ? {1'b1, ot.relaxed_ord, 9'h000,
                           ot.len_dw > 10'h020 ? 10'h020 : ot.len_dw} : 21'h0);
      end
      qp.delete();
      qo.delete();
    end
    $display("test datapath done");
    summarize();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
